/* hw/disp_pkg.sv */
// Shared constants for the panel link: pixel clock divider, line and
// frame geometry, sync widths and the limits that the link must keep.
// Assumes a 125 MHz reference clock at both ends.
package disp_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int REF_CLK_KHZ = 125000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PIX_NOM_KHZ = 6300;
  localparam int PIX_MAX_KHZ = 7000;
  // Round the divide up so the strobe never exceeds the nominal rate
  localparam int DIV = (REF_CLK_KHZ + PIX_NOM_KHZ - 1) / PIX_NOM_KHZ;
  localparam int PIX_KHZ = REF_CLK_KHZ / DIV;
  localparam logic [4:0] DIV_LAST = 5'(DIV - 1);
  localparam logic [4:0] DIV_RISE = 5'(DIV / 2 - 1);

  // ----------------------------------------------------------------
  // Horizontal geometry, in sample strobes
  // ----------------------------------------------------------------
  localparam logic [8:0] LINE_PERIOD = 9'h190;
  localparam logic [8:0] LINE_PERIOD_MIN = 9'h168;
  localparam logic [8:0] LINE_PERIOD_MAX = 9'h1c2;
  localparam logic [8:0] LINE_SYNC_WIDTH = 9'h004;
  localparam logic [8:0] SYNC_WIDTH_MIN = 9'h001;
  localparam logic [8:0] SYNC_WIDTH_MAX = 9'h006;
  localparam logic [8:0] ACTIVE_PIXELS = 9'h140;
  localparam logic [8:0] FIRST_PIXEL_OFFSET = 9'h007;
  localparam logic [8:0] SYNC_PHASE_OFFSET = 9'h000;
  localparam logic [8:0] SYNC_PHASE_MAX = 9'h140;

  // ----------------------------------------------------------------
  // Vertical geometry, in line periods
  // ----------------------------------------------------------------
  localparam logic [8:0] FRAME_PERIOD = 9'h106;
  localparam logic [8:0] FRAME_PERIOD_MIN = 9'h0fb;
  localparam logic [8:0] FRAME_PERIOD_MAX = 9'h118;
  localparam logic [8:0] FRAME_SYNC_WIDTH = 9'h003;
  localparam logic [8:0] FIRST_VISIBLE_LINE_OFFSET = 9'h007;
  localparam logic [8:0] ACTIVE_LINES = 9'h0f0;
  localparam int FRAME_RATE_MIN_HZ = 50;
  localparam int FRAME_RATE_HZ =
    (REF_CLK_KHZ * 1000) / (DIV * 400 * 262);

  // ----------------------------------------------------------------
  // Pixel format
  // ----------------------------------------------------------------
  localparam int COLOR_W = 6;
  localparam logic [8:0] COUNT_SAT = 9'h1ff;

endpackage : disp_pkg

/* hw/panel_link_if.sv */
// Panel link: strobe, syncs, window enable, 18-bit pixel and the two
// scan-direction pins. Controller end drives everything, panel listens.
// Assumes both ends share no clock; the panel samples every wire.
`timescale 1ns/10ps

interface panel_link_if;
  logic       sample_strobe;
  logic       line_sync_n;
  logic       frame_sync_n;
  logic       active_window;
  logic [5:0] red_bits;
  logic [5:0] green_bits;
  logic [5:0] blue_bits;
  logic       mirror_h;
  logic       normal_v;

  modport ctrl (
    output sample_strobe,
    output line_sync_n,
    output frame_sync_n,
    output active_window,
    output red_bits,
    output green_bits,
    output blue_bits,
    output mirror_h,
    output normal_v
  );

  modport panel (
    input sample_strobe,
    input line_sync_n,
    input frame_sync_n,
    input active_window,
    input red_bits,
    input green_bits,
    input blue_bits,
    input mirror_h,
    input normal_v
  );
endinterface : panel_link_if

/* hw/disp_timing_gen.sv */
// Controller end of the panel link: divides the reference clock into
// the sample strobe, counts pixels and lines, drives both syncs, the
// window enable and pixel data fetched from the user side.
// Assumes the user answers a pixel request in the same cycle.
`timescale 1ns/10ps

// Function
// [RL1] Strobe at most 7.0 MHz, near 6.3
// [RL2] Line period 360 to 450 strobes
// [RL3] Line sync low 1 to 6 strobes
// [RL4] Frame lasts 251 to 280 lines
// [RL5] Frame sync low 1 to 6 lines
// [RL6] Frame rate kept at 50 Hz or above
// [RL7] Exactly 320 active pixels per line
// [RL8] Frame sync edge 0 to 320 strobes after line sync
// [RL9] Line 7 after frame sync is first visible
// [RL10] First pixel 7 strobes after line sync
// [RL11] Window enable high 320 strobes per visible line
// [RL12] Window enable never held low permanently
// [RL13] Vertical placement from frame sync only
// [RL14] Syncs active low, window enable active high
// [RL15] Six bits per colour, bit 0 least significant
// [RL16] Direction pins select mirror and flip
// [RL17] Horizontal start follows window enable rise
// [RL18] 240 visible lines, each fed with pixels
module disp_timing_gen (
  // Clock, reset, enable
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CE_IN,
  // Pixel source
  input  wire logic [5:0]  PIX_RED_IN,
  input  wire logic [5:0]  PIX_GREEN_IN,
  input  wire logic [5:0]  PIX_BLUE_IN,
  output logic             PIX_REQ_OUT,
  output logic             LINE_START_OUT,
  output logic             FRAME_START_OUT,
  // Scan direction
  input  wire logic        MIRROR_H_IN,
  input  wire logic        FLIP_V_IN,
  // Link
  panel_link_if.ctrl       LINK
);

  // ----------------------------------------------------------------
  // Strobe divider
  // ----------------------------------------------------------------
  logic [4:0] div_r;
  logic       strobe_r;
  logic       tick;

  // Tick marks the strobe falling edge, where the syncs, window enable and pixel outputs change
  assign tick = CE_IN && (div_r == disp_pkg::DIV_LAST);

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      div_r <= 5'h00;
    else if (tick)
      div_r <= 5'h00;
    else if (CE_IN)
      div_r <= div_r + 5'h01;
  end

  // Half-period high keeps the duty near 50 percent
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      strobe_r <= 1'b0;
    else if (CE_IN && (div_r == disp_pkg::DIV_RISE))
      strobe_r <= 1'b1; // [RL1]
    else if (tick)
      strobe_r <= 1'b0; // [RL1]
  end

  // ----------------------------------------------------------------
  // Pixel and line counters
  // ----------------------------------------------------------------
  logic [8:0] h_r;
  logic [8:0] v_r;
  logic [8:0] h_nxt;
  logic [8:0] v_nxt;
  logic       h_wrap;

  assign h_wrap = (h_r == disp_pkg::LINE_PERIOD - 9'h001);

  always_comb
  begin
    h_nxt = h_wrap ? 9'h000 : h_r + 9'h001; // [RL2]
    v_nxt = v_r;
    if (h_wrap)
    begin
      if (v_r == disp_pkg::FRAME_PERIOD - 9'h001)
        v_nxt = 9'h000; // [RL4] [RL6]
      else
        v_nxt = v_r + 9'h001;
    end
  end

  // Reset parks on the last strobe of the last line, so the first
  // tick opens line 0 of a fresh frame with both syncs falling.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      h_r <= disp_pkg::LINE_PERIOD - 9'h001;
    else if (tick)
      h_r <= h_nxt;
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      v_r <= disp_pkg::FRAME_PERIOD - 9'h001;
    else if (tick)
      v_r <= v_nxt;
  end

  // ----------------------------------------------------------------
  // Window decode for the strobe about to start
  // ----------------------------------------------------------------
  logic win_nxt;
  logic row_nxt;
  logic want_pix;

  assign win_nxt =
    (h_nxt >= disp_pkg::FIRST_PIXEL_OFFSET) &&
    (h_nxt < disp_pkg::FIRST_PIXEL_OFFSET + disp_pkg::ACTIVE_PIXELS);

  // Visible rows counted from frame sync, never from the enable
  assign row_nxt =
    (v_nxt >= disp_pkg::FIRST_VISIBLE_LINE_OFFSET) &&
    (v_nxt < disp_pkg::FIRST_VISIBLE_LINE_OFFSET +
             disp_pkg::ACTIVE_LINES); // [RL9] [RL13] [RL18]

  assign want_pix = win_nxt && row_nxt;

  // ----------------------------------------------------------------
  // Sync and window outputs
  // ----------------------------------------------------------------
  logic line_sync_n_r;
  logic frame_sync_n_r;
  logic active_r;

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      line_sync_n_r <= 1'b1;
    else if (tick)
      line_sync_n_r <= !(h_nxt < disp_pkg::LINE_SYNC_WIDTH); // [RL3] [RL14]
  end

  // Frame sync only moves when the pixel counter wraps, so its edge
  // lands on the line sync edge: zero phase.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      frame_sync_n_r <= 1'b1;
    else if (tick)
      frame_sync_n_r <= !(v_nxt < disp_pkg::FRAME_SYNC_WIDTH); // [RL5] [RL8]
  end

  // Enable runs on every line, blanking lines too, so it never sits
  // low for a whole frame and the panel always sees a rising edge.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      active_r <= 1'b0;
    else if (tick)
      active_r <= win_nxt; // [RL10] [RL11] [RL12] [RL17]
  end

  // ----------------------------------------------------------------
  // Pixel data
  // ----------------------------------------------------------------
  logic [5:0] red_r;
  logic [5:0] green_r;
  logic [5:0] blue_r;

  assign PIX_REQ_OUT = tick && want_pix; // [RL7]

  // Outside the picture the bus is held at black
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      red_r   <= 6'h00;
      green_r <= 6'h00;
      blue_r  <= 6'h00;
    end
    else if (tick)
    begin
      red_r   <= want_pix ? PIX_RED_IN : 6'h00; // [RL15]
      green_r <= want_pix ? PIX_GREEN_IN : 6'h00;
      blue_r  <= want_pix ? PIX_BLUE_IN : 6'h00;
    end
  end

  // ----------------------------------------------------------------
  // Direction pins and user markers
  // ----------------------------------------------------------------
  logic mirror_r;
  logic normal_r;

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      mirror_r <= 1'b0;
      normal_r <= 1'b1;
    end
    else if (CE_IN)
    begin
      mirror_r <= MIRROR_H_IN; // [RL16]
      normal_r <= !FLIP_V_IN;
    end
  end

  assign LINE_START_OUT  = tick && (h_nxt == 9'h000);
  assign FRAME_START_OUT = tick && h_wrap && (v_nxt == 9'h000);

  assign LINK.sample_strobe = strobe_r;
  assign LINK.line_sync_n   = line_sync_n_r;
  assign LINK.frame_sync_n  = frame_sync_n_r;
  assign LINK.active_window = active_r;
  assign LINK.red_bits      = red_r;
  assign LINK.green_bits    = green_r;
  assign LINK.blue_bits     = blue_r;
  assign LINK.mirror_h      = mirror_r;
  assign LINK.normal_v      = normal_r;

endmodule : disp_timing_gen

/* hw/disp_panel_rx.sv */
// Panel end of the link: samples every wire on the local clock, finds
// strobe rising edges, places pixels and lines and hands them out with
// screen coordinates after mirror and flip.
// Assumes strobe half periods well above three local clock periods.
`timescale 1ns/10ps

module disp_panel_rx (
  // Clock, reset, enable
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CE_IN,
  // Link
  panel_link_if.panel      LINK,
  // Pixel sink
  output logic             PIX_VALID_OUT,
  output logic [8:0]       PIX_X_OUT,
  output logic [7:0]       PIX_Y_OUT,
  output logic [17:0]      PIX_RGB_OUT,
  // Status
  output logic             FRAME_START_OUT,
  output logic             HPOS_ERR_OUT
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  localparam int SW = 24;
  logic [SW-1:0] raw;
  logic [SW-1:0] meta_r;
  logic [SW-1:0] s_r;
  logic          strobe_d_r;

  assign raw = {LINK.sample_strobe, LINK.line_sync_n, LINK.frame_sync_n,
                LINK.active_window, LINK.mirror_h, LINK.normal_v,
                LINK.red_bits, LINK.green_bits, LINK.blue_bits};

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      meta_r     <= '0;
      s_r        <= '0;
      strobe_d_r <= 1'b0;
    end
    else if (CE_IN)
    begin
      meta_r     <= raw;
      s_r        <= meta_r;
      strobe_d_r <= s_r[23];
    end
  end

  // ----------------------------------------------------------------
  // Edge detection at each strobe rise
  // ----------------------------------------------------------------
  logic se;
  logic hs_n;
  logic vs_n;
  logic act;
  logic prev_hs_r;
  logic prev_vs_r;
  logic prev_act_r;
  logic hs_fall;
  logic vs_fall;
  logic act_rise;

  assign se       = CE_IN && s_r[23] && !strobe_d_r;
  assign hs_n     = s_r[22];
  assign vs_n     = s_r[21];
  assign act      = s_r[20];
  assign hs_fall  = prev_hs_r && !hs_n; // [RL14]
  assign vs_fall  = prev_vs_r && !vs_n;
  assign act_rise = !prev_act_r && act;

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      prev_hs_r  <= 1'b1;
      prev_vs_r  <= 1'b1;
      prev_act_r <= 1'b0;
    end
    else if (se)
    begin
      prev_hs_r  <= hs_n;
      prev_vs_r  <= vs_n;
      prev_act_r <= act;
    end
  end

  // ----------------------------------------------------------------
  // Position counters
  // ----------------------------------------------------------------
  logic [8:0] hcnt_r;
  logic [8:0] line_r;
  logic [8:0] hcnt_nxt;
  logic [8:0] row_full;
  logic       row_vis;

  assign hcnt_nxt = hs_fall ? 9'h000 :
                    (hcnt_r == disp_pkg::COUNT_SAT) ? hcnt_r :
                    hcnt_r + 9'h001;

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      hcnt_r <= disp_pkg::COUNT_SAT;
    else if (se)
      hcnt_r <= hcnt_nxt;
  end

  // Lines count from frame sync alone; the enable plays no part
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      line_r <= disp_pkg::COUNT_SAT;
    else if (se && vs_fall)
      line_r <= 9'h000; // [RL13]
    else if (se && hs_fall && (line_r != disp_pkg::COUNT_SAT))
      line_r <= line_r + 9'h001;
  end

  assign row_full = line_r - disp_pkg::FIRST_VISIBLE_LINE_OFFSET;
  assign row_vis  =
    (line_r >= disp_pkg::FIRST_VISIBLE_LINE_OFFSET) &&
    (row_full < disp_pkg::ACTIVE_LINES); // [RL9] [RL18]

  // ----------------------------------------------------------------
  // Column run, started by the enable rise
  // ----------------------------------------------------------------
  logic [8:0] col_r;
  logic       run_r;
  logic [8:0] col;
  logic       take;

  assign col  = act_rise ? 9'h000 : col_r; // [RL17]
  assign take = se && act && (act_rise || run_r) && row_vis;

  // The run stops after the last column even if the enable stays high
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      run_r <= 1'b0;
      col_r <= 9'h000;
    end
    else if (se)
    begin
      if (act_rise || (run_r && act))
        col_r <= col + 9'h001;
      if (!act || (col == disp_pkg::ACTIVE_PIXELS - 9'h001))
        run_r <= 1'b0; // [RL7]
      else if (act_rise)
        run_r <= 1'b1;
    end
  end

  // Enable rising anywhere but the fixed offset is flagged per line
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
      HPOS_ERR_OUT <= 1'b0;
    else if (se && act_rise)
      HPOS_ERR_OUT <= (hcnt_nxt != disp_pkg::FIRST_PIXEL_OFFSET); // [RL10]
  end

  // ----------------------------------------------------------------
  // Pixel output with scan direction
  // ----------------------------------------------------------------
  logic [8:0] y_full;

  assign y_full = s_r[18] ? row_full :
                  disp_pkg::ACTIVE_LINES - 9'h001 - row_full;

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      PIX_VALID_OUT   <= 1'b0;
      PIX_X_OUT       <= 9'h000;
      PIX_Y_OUT       <= 8'h00;
      PIX_RGB_OUT     <= 18'h00000;
      FRAME_START_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      PIX_VALID_OUT   <= take;
      FRAME_START_OUT <= se && vs_fall;
      if (take)
      begin
        PIX_X_OUT   <= s_r[19] ? disp_pkg::ACTIVE_PIXELS - 9'h001 - col
                               : col; // [RL16]
        PIX_Y_OUT   <= y_full[7:0]; // [RL16]
        PIX_RGB_OUT <= s_r[17:0]; // [RL15]
      end
    end
  end

endmodule : disp_panel_rx

/* testbench/panel_link_asserts.sv */
// Link checker: strobe rate, line and frame geometry, sync widths
// and window placement, judged on the wires alone.
// Assumes the controller end drives the link; instantiated, no bind.
`timescale 1ns/10ps

module panel_link_asserts (
  // Clock and reset
  input wire logic       REF_CLK_IN,
  input wire logic       RST_IN,
  // Link wires
  input wire logic       sample_strobe,
  input wire logic       line_sync_n,
  input wire logic       frame_sync_n,
  input wire logic       active_window,
  input wire logic [5:0] red_bits,
  input wire logic [5:0] green_bits,
  input wire logic [5:0] blue_bits,
  input wire logic       mirror_h,
  input wire logic       normal_v
);
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  // ----------------------------------------------------------------
  // Strobe, line and frame bookkeeping
  // ----------------------------------------------------------------
  logic       st_q_r;
  logic       ls_q_r;
  logic       fs_q_r;
  logic       aw_q_r;
  logic       lseen_r;
  logic       fseen_r;
  logic [8:0] h_cnt_r;
  logic [8:0] v_cnt_r;
  logic       tick;
  logic       ls_fall;
  logic       fs_fall;

  // Syncs, window and pixel bits only change where the strobe falls
  assign tick    = st_q_r & ~sample_strobe;
  assign ls_fall = tick & ls_q_r & ~line_sync_n;
  assign fs_fall = tick & fs_q_r & ~frame_sync_n;

  always_ff @(posedge REF_CLK_IN)
  begin
    st_q_r <= sample_strobe;
    ls_q_r <= line_sync_n;
    fs_q_r <= frame_sync_n;
    aw_q_r <= active_window;
  end

  // Counts mean nothing until a first sync edge has been seen
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      h_cnt_r <= 9'h000;
      lseen_r <= 1'b0;
    end
    else if (tick)
    begin
      h_cnt_r <= ls_fall ? 9'h000 : h_cnt_r + 9'h001;
      lseen_r <= lseen_r | ls_fall;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      v_cnt_r <= 9'h000;
      fseen_r <= 1'b0;
    end
    else if (ls_fall)
    begin
      v_cnt_r <= fs_fall ? 9'h000 : v_cnt_r + 9'h001;
      fseen_r <= fseen_r | fs_fall;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_strobe_period;
    $rose(sample_strobe) |-> ##20 $rose(sample_strobe);
  endproperty
  a_strobe_period: assert property (p_strobe_period)
    else $error("strobe period wrong");

  property p_line_period;
    ls_fall && lseen_r |-> h_cnt_r == disp_pkg::LINE_PERIOD - 9'h001;
  endproperty
  a_line_period: assert property (p_line_period)
    else $error("line period wrong");

  property p_line_sync_width;
    tick && !ls_q_r && line_sync_n && lseen_r
      |-> h_cnt_r == disp_pkg::LINE_SYNC_WIDTH - 9'h001;
  endproperty
  a_line_sync_width: assert property (p_line_sync_width)
    else $error("line sync width wrong");

  property p_frame_period;
    fs_fall && fseen_r |-> v_cnt_r == disp_pkg::FRAME_PERIOD - 9'h001;
  endproperty
  a_frame_period: assert property (p_frame_period)
    else $error("frame period wrong");

  property p_frame_sync_width;
    tick && !fs_q_r && frame_sync_n && fseen_r
      |-> v_cnt_r == disp_pkg::FRAME_SYNC_WIDTH - 9'h001;
  endproperty
  a_frame_sync_width: assert property (p_frame_sync_width)
    else $error("frame sync width wrong");

  property p_sync_phase;
    fs_fall |-> ls_fall;
  endproperty
  a_sync_phase: assert property (p_sync_phase)
    else $error("frame sync not on line sync");

  property p_window_start;
    tick && !aw_q_r && active_window && lseen_r
      |-> h_cnt_r == disp_pkg::FIRST_PIXEL_OFFSET - 9'h001;
  endproperty
  a_window_start: assert property (p_window_start)
    else $error("window rise misplaced");

  property p_window_width;
    tick && aw_q_r && !active_window |-> h_cnt_r ==
      disp_pkg::FIRST_PIXEL_OFFSET + disp_pkg::ACTIVE_PIXELS - 9'h001;
  endproperty
  a_window_width: assert property (p_window_width)
    else $error("window width wrong");

  // Pixel bits and syncs may only move where the strobe falls
  property p_data_on_fall;
    !tick |-> $stable({red_bits, green_bits, blue_bits, active_window,
                       line_sync_n, frame_sync_n});
  endproperty
  a_data_on_fall: assert property (p_data_on_fall)
    else $error("link data moved off strobe fall");

endmodule : panel_link_asserts

/* testbench/tb_qvga_panel_input_timing.sv */
// Bench: controller and panel face each other and pixels flow end to
// end; a second panel is fed a hand-made link with a bad offset.
// Assumes the design package, the link interface, both design modules and the link checker.
`timescale 1ns/10ps

`define CHECK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end

module tb_qvga_panel_input_timing;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mir_h = 1'b1;
  logic        flip_v = 1'b1;
  logic [5:0]  red = 6'h00;
  logic [5:0]  green = 6'h00;
  logic [5:0]  blue = 6'h00;
  logic        pix_req;
  logic        valid;
  logic        hpos_err;
  logic        hpos_err2;
  logic        fs_out;
  logic        ls_start;
  logic        fs_start;
  logic [8:0]  pix_x;
  logic [7:0]  pix_y;
  logic [17:0] rgb;
  logic        ls_q = 1'b1;
  logic        fs_q = 1'b1;
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          req_col = 0;
  int          req_row = 0;
  int          k = 0;
  int          r = 0;
  int          ln_w = 0;
  int          frames = 0;
  int          n_ls = 0;
  int          n_fs = 0;
  int          ln_t = 0;
  int          ln_ns = 0;
  int          exp_ns = 0;
  int          fr_hz = 0;

  panel_link_if link_if ();
  panel_link_if bad_if ();

  disp_timing_gen disp_timing_gen_i (
    .REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
    .PIX_RED_IN(red), .PIX_GREEN_IN(green), .PIX_BLUE_IN(blue),
    .PIX_REQ_OUT(pix_req), .LINE_START_OUT(ls_start),
    .FRAME_START_OUT(fs_start),
    .MIRROR_H_IN(mir_h), .FLIP_V_IN(flip_v), .LINK(link_if.ctrl));

  disp_panel_rx disp_panel_rx_i (
    .REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .LINK(link_if.panel),
    .PIX_VALID_OUT(valid), .PIX_X_OUT(pix_x), .PIX_Y_OUT(pix_y),
    .PIX_RGB_OUT(rgb), .FRAME_START_OUT(fs_out), .HPOS_ERR_OUT(hpos_err));

  disp_panel_rx disp_panel_rx_f_i (
    .REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .LINK(bad_if.panel),
    .PIX_VALID_OUT(), .PIX_X_OUT(), .PIX_Y_OUT(), .PIX_RGB_OUT(),
    .FRAME_START_OUT(), .HPOS_ERR_OUT(hpos_err2));

  panel_link_asserts panel_link_asserts_i (
    .REF_CLK_IN(clk), .RST_IN(rst),
    .sample_strobe(link_if.sample_strobe),
    .line_sync_n(link_if.line_sync_n),
    .frame_sync_n(link_if.frame_sync_n),
    .active_window(link_if.active_window),
    .red_bits(link_if.red_bits), .green_bits(link_if.green_bits),
    .blue_bits(link_if.blue_bits), .mirror_h(link_if.mirror_h),
    .normal_v(link_if.normal_v));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Pixel source and scan mode; mode moves on after each full row
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst && pix_req === 1'b1)
    begin
      req_col <= (req_col == 319) ? 0 : req_col + 1;
      req_row <= (req_col == 319) ? req_row + 1 : req_row;
    end
  end

  always @(negedge clk)
  begin
    red <= 6'(req_col);
    green <= 6'(req_col >> 3);
    blue <= 6'(req_row);
    mir_h <= 1'((r + 7) & 1);
    flip_v <= 1'(((r + 7) >> 1) & 1);
  end

  // ----------------------------------------------------------------
  // Panel side monitor
  // ----------------------------------------------------------------
  task automatic check_pixel();
    logic [8:0] ln;
    logic [8:0] ex;
    logic [7:0] ey;
    ln = 9'(r + 7);
    ex = ln[0] ? 9'(319 - k) : 9'(k);
    ey = ln[1] ? 8'(239 - r) : 8'(r);
    if (k == 0) `CHECK(ln_w, r + 7)
    `CHECK(pix_x, ex)
    `CHECK(pix_y, ey)
    `CHECK(rgb, {6'(k), 6'(k >> 3), 6'(r)})
    `CHECK(hpos_err, 1'b0)
    k++;
    if (k == 320)
    begin
      k = 0;
      r++;
    end
  endtask : check_pixel

  always @(posedge clk)
  begin
    ls_q <= link_if.line_sync_n;
    fs_q <= link_if.frame_sync_n;
    if (fs_q && !link_if.frame_sync_n)
      ln_w <= 0;
    else if (ls_q && !link_if.line_sync_n)
      ln_w <= ln_w + 1;
    // Line length measured on the wire between sync falls
    if (ls_q && !link_if.line_sync_n)
    begin
      ln_ns <= int'($time) - ln_t;
      ln_t  <= int'($time);
    end
    if (ls_start === 1'b1)
      n_ls <= n_ls + 1;
    if (fs_start === 1'b1)
      n_fs <= n_fs + 1;
    if (fs_out === 1'b1)
      frames <= frames + 1;
    if (valid === 1'b1)
      check_pixel();
  end

  // Hand-made link line at 64 ns strobes, window rising at off
  task automatic bad_line(input int off, input logic first);
    for (int i = 0; i < 12; i++)
    begin
      bad_if.line_sync_n = (i > 3);
      bad_if.frame_sync_n = !first;
      bad_if.active_window = (i >= off) && (i < off + 3);
      #32 bad_if.sample_strobe = 1'b1;
      #32 bad_if.sample_strobe = 1'b0;
    end
  endtask : bad_line

  task automatic complete_run();
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 99000)
    begin
      n_errors++;
      complete_run();
    end
  end

  initial
  begin
    bad_if.sample_strobe = 1'b0;
    bad_if.line_sync_n = 1'b1;
    bad_if.frame_sync_n = 1'b1;
    bad_if.active_window = 1'b0;
    bad_if.red_bits = 6'h00;
    bad_if.green_bits = 6'h00;
    bad_if.blue_bits = 6'h00;
    bad_if.mirror_h = 1'b0;
    bad_if.normal_v = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    bad_line(8, 1'b1);
    `CHECK(hpos_err2, 1'b1)
    bad_line(7, 1'b0);
    `CHECK(hpos_err2, 1'b0)
    wait (r == 5);
    `CHECK(frames, 1)
    exp_ns = disp_pkg::LINE_PERIOD * disp_pkg::DIV * disp_pkg::CLK_PERIOD_NS;
    `CHECK(ln_ns, exp_ns)
    fr_hz = 1000000000 / (ln_ns * int'(disp_pkg::FRAME_PERIOD));
    `CHECK(fr_hz >= disp_pkg::FRAME_RATE_MIN_HZ, 1'b1)
    `CHECK(n_ls, int'(disp_pkg::FIRST_VISIBLE_LINE_OFFSET) + 5)
    `CHECK(n_fs, 1)
    complete_run();
  end

endmodule : tb_qvga_panel_input_timing
